// [pkg/bad_pkg.sv]
// Package of constants and types for the board address decoder
//   Function
// - Select on-board RAM for addresses 0000 to 0FFF.
// - Select the three parallel port adapters at 5800 to 580B, four bytes each.
// - Select program ROM for addresses C000 to CFFF.
// - Partial decode makes aliases; external modules must avoid alias regions.
// - Adapter interrupt requests combine onto the processor maskable interrupt.
// - Generate a 1 MHz two-phase processor clock that can be stretched.
// - Hold the processor in reset for a timed interval after power-up.
// - Provide refresh support for external dynamic memory modules.
package bad_pkg;

  // ************************************************************
  // Address map
  // ************************************************************
  localparam logic [15:0] BAD_RAM_MASK  = 16'hF000;
  localparam logic [15:0] BAD_RAM_BASE  = 16'h0000;
  localparam logic [15:0] BAD_PPA_MASK  = 16'hF800;
  localparam logic [15:0] BAD_PPA_BASE  = 16'h5800;
  localparam logic [15:0] BAD_ROM_MASK  = 16'hF000;
  localparam logic [15:0] BAD_ROM_BASE  = 16'hC000;
  localparam int          BAD_PPA_SEL_LSB = 2;
  localparam int          BAD_NUM_PPA     = 3;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int BAD_SYS_CLK_HZ     = 25_000_000;
  localparam int BAD_CPU_CLK_HZ     = 1_000_000;
  localparam int BAD_HALF_CYC       = BAD_SYS_CLK_HZ / (2 * BAD_CPU_CLK_HZ);
  localparam int BAD_POR_TIME_MS    = 10;
  localparam int BAD_POR_CYC        = BAD_POR_TIME_MS * (BAD_SYS_CLK_HZ / 1000);
  localparam int BAD_REFRESH_US     = 16;
  localparam int BAD_REFRESH_CYC    = BAD_REFRESH_US * (BAD_SYS_CLK_HZ / 1_000_000);
  localparam int BAD_CNT_W          = 20;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic       ram;
    logic [2:0] ppa;
    logic       rom;
  } bad_sel_s;

  typedef struct packed {
    logic           phi1;
    logic           phi2;
    logic [4:0]     half_cnt;
    logic [BAD_CNT_W-1:0] por_cnt;
    logic           cpu_rst_n;
    logic [BAD_CNT_W-1:0] ref_cnt;
    logic           ref_req;
    logic           irq_n;
    bad_sel_s       sel;
  } bad_state_s;

endpackage

// [core/bad_decoder.sv]
// Board address decoder, clock, reset timer, refresh and interrupt logic
`timescale 1ns/1ns
`default_nettype none
module bad_decoder
  import bad_pkg::*;
#(
  parameter int POR_CYC     = BAD_POR_CYC,
  parameter int REFRESH_CYC = BAD_REFRESH_CYC
) (
  // Clock and reset
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst,
  // Processor address bus
  input  wire logic [15:0]            i_addr,
  input  wire logic                   i_vma,
  // Clock stretch request from slow or dynamic memory
  input  wire logic                   i_stretch,
  // Refresh grant from external dynamic memory
  input  wire logic                   i_ref_ack,
  // Adapter interrupt requests, active low
  input  wire logic [BAD_NUM_PPA-1:0] i_ppa_irq_n,
  // Chip selects
  output logic                        o_ram_sel,
  output logic [BAD_NUM_PPA-1:0]      o_ppa_sel,
  output logic                        o_rom_sel,
  // Processor clock, reset and interrupt
  output logic                        o_phi1,
  output logic                        o_phi2,
  output logic                        o_cpu_rst_n,
  output logic                        o_cpu_irq_n,
  // Refresh request
  output logic                        o_ref_req
);

  // ************************************************************
  // Local constants
  // ************************************************************
  // Last count of a half period of the processor clock
  localparam logic [4:0] HALF_LAST  = 5'(BAD_HALF_CYC - 1);
  localparam int         PPA_CODE_W = 2;

  // ************************************************************
  // State
  // ************************************************************
  bad_state_s state_ff;
  bad_state_s nxt_state;

  // Reset image: selects off, phase 1 high, processor held in reset
  localparam bad_state_s RST_STATE = '{
    phi1:      1'b1,
    phi2:      1'b0,
    half_cnt:  5'h00,
    por_cnt:   '0,
    cpu_rst_n: 1'b0,
    ref_cnt:   '0,
    ref_req:   1'b0,
    irq_n:     1'b1,
    sel:       '0
  };

  // ************************************************************
  // Decode helpers
  // ************************************************************
  // Address falls inside a masked region
  function automatic logic in_region(
    input logic [15:0] a,
    input logic [15:0] mask,
    input logic [15:0] base
  );
    logic hit;
    hit = ((a & mask) == base);
    return hit;
  endfunction

  // Adapter number to one-hot select; code 3 selects nothing
  function automatic logic [BAD_NUM_PPA-1:0] ppa_onehot(input logic [PPA_CODE_W-1:0] code);
    logic [BAD_NUM_PPA-1:0] hot;
    hot = '0;
    unique case (code)
      2'h0: begin
        hot = 3'h1;
      end
      2'h1: begin
        hot = 3'h2;
      end
      2'h2: begin
        hot = 3'h4;
      end
      default: begin
        hot = '0;
      end
    endcase
    return hot;
  endfunction

  // ************************************************************
  // Counter helpers
  // ************************************************************
  // Counter stands at the last count of a span of lim cycles
  function automatic logic cnt_done(
    input logic [BAD_CNT_W-1:0] cnt,
    input int                   lim
  );
    logic done;
    done = (cnt == BAD_CNT_W'(lim - 1));
    return done;
  endfunction

  // Counter plus one, kept at counter width
  function automatic logic [BAD_CNT_W-1:0] cnt_inc(input logic [BAD_CNT_W-1:0] cnt);
    logic [BAD_CNT_W-1:0] nxt;
    nxt = cnt + BAD_CNT_W'(1);
    return nxt;
  endfunction

  // Phase counter at the end of a half period
  function automatic logic half_done(input logic [4:0] cnt);
    logic done;
    done = (cnt == HALF_LAST);
    return done;
  endfunction

  // ************************************************************
  // Partial decode
  // ************************************************************
  // Adapter address bits 10:4 are ignored, so only the adapters show up in images across 5800 to 5FFF
  function automatic bad_sel_s decode(input logic [15:0] a, input logic v);
    bad_sel_s s;
    s = '0;
    if (v) begin
      if (in_region(a, BAD_RAM_MASK, BAD_RAM_BASE)) begin
        s.ram = 1'b1;
      end else if (in_region(a, BAD_PPA_MASK, BAD_PPA_BASE)) begin
        // Bits 3:2 pick the adapter
        s.ppa = ppa_onehot(a[BAD_PPA_SEL_LSB +: PPA_CODE_W]);
      end else if (in_region(a, BAD_ROM_MASK, BAD_ROM_BASE)) begin
        s.rom = 1'b1;
      end
    end
    return s;
  endfunction

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    nxt_state     = state_ff;
    nxt_state.sel = decode(i_addr, i_vma);

    // ************************************************************
    // Two-phase clock; phase 2 high is held while stretched
    // ************************************************************
    if (state_ff.phi2 && i_stretch) begin
      nxt_state.half_cnt = state_ff.half_cnt;
    end else if (half_done(state_ff.half_cnt)) begin
      nxt_state.half_cnt = 5'h00;
      nxt_state.phi1     = state_ff.phi2;
      nxt_state.phi2     = state_ff.phi1;
    end else begin
      nxt_state.half_cnt = state_ff.half_cnt + 5'h01;
    end

    // ************************************************************
    // Power-on reset timer, stops at its last count
    // ************************************************************
    if (!cnt_done(state_ff.por_cnt, POR_CYC)) begin
      nxt_state.por_cnt   = cnt_inc(state_ff.por_cnt);
      nxt_state.cpu_rst_n = 1'b0;
    end else begin
      nxt_state.cpu_rst_n = 1'b1;
    end

    // ************************************************************
    // Refresh request, held until granted; a new request wins
    // ************************************************************
    if (cnt_done(state_ff.ref_cnt, REFRESH_CYC)) begin
      nxt_state.ref_cnt = '0;
      nxt_state.ref_req = 1'b1;
    end else begin
      nxt_state.ref_cnt = cnt_inc(state_ff.ref_cnt);
      if (i_ref_ack) begin
        nxt_state.ref_req = 1'b0;
      end
    end

    // ************************************************************
    // Interrupt: adapter lines wired together, active low
    // ************************************************************
    nxt_state.irq_n = &i_ppa_irq_n;
  end

  // ************************************************************
  // State register
  // ************************************************************
  // Synchronous reset restores the reset image
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_ff <= RST_STATE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Chip selects
  assign o_ram_sel   = state_ff.sel.ram;
  assign o_ppa_sel   = state_ff.sel.ppa;
  assign o_rom_sel   = state_ff.sel.rom;

  // Processor clock, reset and interrupt
  assign o_phi1      = state_ff.phi1;
  assign o_phi2      = state_ff.phi2;
  assign o_cpu_rst_n = state_ff.cpu_rst_n;
  assign o_cpu_irq_n = state_ff.irq_n;

  // Refresh
  assign o_ref_req   = state_ff.ref_req;

endmodule
`default_nettype wire

// [tb/bad_checker.sv]
// Assertions on the board address decoder ports
`timescale 1ns/1ns
`default_nettype none
module bad_checker (
  // Watched ports
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  input wire logic [15:0] i_addr,
  input wire logic        i_vma,
  input wire logic [2:0]  i_ppa_irq_n,
  input wire logic        o_ram_sel,
  input wire logic [2:0]  o_ppa_sel,
  input wire logic        o_rom_sel,
  input wire logic        o_phi1,
  input wire logic        o_phi2,
  input wire logic        i_stretch,
  input wire logic        i_ref_ack,
  input wire logic        o_ref_req,
  input wire logic        o_cpu_rst_n,
  input wire logic        o_cpu_irq_n);
  logic [5:0] e_q;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  always_ff @(posedge i_sys_clk)
    e_q <= {{5{i_vma && !i_rst}} & {i_addr[15:12] == 4'h0,
      i_addr[15:11] == 5'h0B && i_addr[3:2] != 2'h3 ? 3'h1 << i_addr[3:2] : 3'h0,
      i_addr[15:12] == 4'hC}, &i_ppa_irq_n | i_rst};
  ram_sel_a: assert property (o_ram_sel == e_q[5]) else $error("ram");
  port_sel_a: assert property (o_ppa_sel == e_q[4:2]) else $error("adapter");
  rom_sel_a: assert property (o_rom_sel == e_q[1]) else $error("rom");
  one_sel_a: assert property ($onehot0({o_ram_sel, o_ppa_sel, o_rom_sel})) else $error("multi");
  irq_join_a: assert property (o_cpu_irq_n == e_q[0]) else $error("irq");
  phase_len_a: assert property ($rose(o_phi1) |-> ##11 o_phi1 ##1 !o_phi1) else $error("phase");
  por_hold_a: assert property ($fell(i_rst) |-> !o_cpu_rst_n [*8]) else $error("reset");
  por_stay_a: assert property (o_cpu_rst_n |=> o_cpu_rst_n) else $error("reset");
  phase_pair_a: assert property (o_phi1 != o_phi2) else $error("phase pair");
  stretch_hold_a: assert property (i_stretch && o_phi2 |=> o_phi2) else $error("stretch");
  ref_hold_a: assert property (o_ref_req && !i_ref_ack |=> o_ref_req) else $error("refresh");
endmodule
bind bad_decoder bad_checker u_chk (.*);
`default_nettype wire

// [tb/bad_partner.sv]
// Dynamic memory module that grants refresh promptly or slowly
`timescale 1ns/1ns
`default_nettype none
module bad_partner (
  // Clock, pace and refresh handshake
  input  wire logic i_sys_clk,
  input  wire logic i_slow,
  input  wire logic i_ref_req,
  output logic      o_ref_ack = 1'b0);
  always @(posedge i_sys_clk)
    o_ref_ack <= i_ref_req && !o_ref_ack && (!i_slow || $urandom % 16 == 0);
endmodule
`default_nettype wire

// [tb/bad_decoder_tb.sv]
// Self-checking testbench of the board address decoder
`timescale 1ns/1ns
`default_nettype none
module bad_decoder_tb;
  logic        i_sys_clk = 0, i_rst = 1, i_vma = 0, i_stretch = 0, i_ref_ack;
  logic [15:0] i_addr = 16'h0000;
  logic [2:0]  i_ppa_irq_n = 3'h7, o_ppa_sel;
  logic        o_ram_sel, o_rom_sel, o_phi1, o_phi2, o_cpu_rst_n, o_cpu_irq_n, o_ref_req;
  int          n_errors = 0, num_checks = 0, refs = 0;
  logic [15:0] corner [8] = '{16'h03FF, 16'h0400, 16'h1000, 16'h580B,
                              16'h580C, 16'h5FFF, 16'hCFFF, 16'hD000};
  // Expected selects {ram, adapter[2:0], rom} for an address
  function automatic logic [4:0] exp_sel(logic [15:0] a, logic v);
    if (!v) return 5'h00;
    if (a < 16'h1000) return 5'h10;
    if (a >= 16'h5800 && a < 16'h6000) return (a[3:2] == 2'h3) ? 5'h00 : 5'(4'h2 << a[3:2]);
    if (a >= 16'hC000 && a < 16'hD000) return 5'h01;
    return 5'h00;
  endfunction
  always #20 i_sys_clk = ~i_sys_clk;
  always @(posedge o_ref_req) refs++;
  bad_decoder #(.POR_CYC(20), .REFRESH_CYC(30)) DUT (.*);
  bad_partner PM (.i_sys_clk, .i_slow(refs > 20), .i_ref_req(o_ref_req), .o_ref_ack(i_ref_ack));
  task automatic check(string what, logic [4:0] e, logic [4:0] got);
    num_checks++;
    if (got !== e) $display("CHECK FAILED %s expected %b seen %b", what, e, got);
    n_errors += (got !== e);
  endtask
  task automatic final_report(int late);
    n_errors += late;
    if (n_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial #400000 final_report(1);
  initial begin
    void'($urandom(82729));
    #641 i_rst = 0;
    for (int i = 0; i < 3000; i++) begin
      @(posedge i_sys_clk);
      #1 check("selects", exp_sel(i_addr, i_vma), {o_ram_sel, o_ppa_sel, o_rom_sel});
      check("irq", {4'h0, &i_ppa_irq_n}, {4'h0, o_cpu_irq_n});
      check("phase 2", {4'h0, !o_phi1}, {4'h0, o_phi2});
      i_addr = i < 8 ? corner[i] : 16'($urandom) & (i % 2 ? 16'hFFFF : 16'hF80F);
      {i_vma, i_stretch, i_ppa_irq_n} = 5'($urandom) | (i < 8 ? 5'h10 : 5'h00);
      if (i == 2 || i == 40) check("cpu reset", i == 40, o_cpu_rst_n);
    end
    check("refresh", 1'b1, refs > 10);
    final_report(0);
  end
endmodule
`default_nettype wire
